// file: hvsp_port.sv
`timescale 1ns/1ps
module hvsp_port #(
	parameter int FLASH_AW = 9,
	parameter int EE_AW = 6,
	parameter int STARTUP_CYC = hvsp_pkg::STARTUP_CYCLES,
	parameter int WRITE_CYC = hvsp_pkg::WRITE_CYCLES,
	// signature and calibration values are arbitrary
	parameter logic [7:0] SIG0 = 8'hA1,
	parameter logic [7:0] SIG1 = 8'hB2,
	parameter logic [7:0] SIG2 = 8'hC3,
	parameter logic [7:0] CALIB = 8'h5A
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic serial_clock_in_pin,
	input wire logic serial_data_in_pin,
	input wire logic serial_instr_in_pin,
	input wire logic reset_high_voltage_pin,
	input wire logic high_voltage_detect,
	output logic ready_busy_data_out_pin,
	output logic ready_busy_oe_n,
	output logic ext_reset_n,
	output logic core_run,
	output logic brownout_enable,
	output logic brownout_level,
	output logic [1:0] startup_select,
	output logic [7:0] oscillator_trim_register,
	output logic low_voltage_mode
);
	import hvsp_pkg::*;

	localparam logic [15:0] WR_T = 16'(WRITE_CYC);
	localparam logic [15:0] WR_T2 = 16'(2 * WRITE_CYC);
	localparam logic [23:0] START_T = 24'(STARTUP_CYC);
	localparam logic [FLASH_AW-1:0] IDX_LAST = '1;

	// pin synchronisers, three stages with agreement filter
	logic [4:0] pin_raw;
	logic [4:0] s1_q;
	logic [4:0] s2_q;
	logic [4:0] s3_q;
	logic [4:0] filt_q;
	assign pin_raw = {high_voltage_detect, reset_high_voltage_pin,
		serial_instr_in_pin, serial_data_in_pin, serial_clock_in_pin};

	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_sync
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					s1_q[g] <= 1'b0;
					s2_q[g] <= 1'b0;
					s3_q[g] <= 1'b0;
					filt_q[g] <= 1'b0;
				end else begin
					s1_q[g] <= pin_raw[g];
					s2_q[g] <= s1_q[g];
					s3_q[g] <= s2_q[g];
					if (s2_q[g] == s3_q[g]) begin
						filt_q[g] <= s3_q[g];
					end
				end
			end
		end
	endgenerate

	wire sck_f = filt_q[0];
	wire sdi_f = filt_q[1];
	wire sii_f = filt_q[2];
	wire rst_f = filt_q[3];
	wire hv_f = filt_q[4];

	logic sck_prev_q;
	logic lv_mode_q;
	logic lv_req_q;
	logic [3:0] pulse_q;
	logic [3:0] bit_q;
	logic [9:0] di_sr_q;
	logic [9:0] ii_sr_q;
	logic [7:0] cmd_q;
	logic [FLASH_AW-1:0] addr_q;
	logic [7:0] data_lo_q;
	logic [7:0] data_hi_q;
	logic arm_lo_q;
	logic arm_hi_q;
	logic [5:0] fuse_q;
	logic [5:0] fuse_act_q;
	logic [1:0] lock_q;
	logic [15:0] timer_q;
	logic sweep_q;
	logic [FLASH_AW-1:0] idx_q;
	logic [10:0] out_sr_q;
	logic out_act_q;
	logic pin_out_q;
	logic oe_n_q;
	logic ext_rst_n_q;
	logic [23:0] start_cnt_q;
	logic run_q;
	logic bod_en_q;
	logic [7:0] trim_q;
	logic ack_q;
	logic [31:0] dat_q;

	logic [7:0] flash_lo [1 << FLASH_AW];
	logic [7:0] flash_hi [1 << FLASH_AW];
	logic [7:0] ee_mem [1 << EE_AW];

	// programming mode: 12V present or a granted low-voltage session
	// entry on 12V, or on a low-voltage request granted while 12V is absent
	wire prog_mode = hv_f | lv_mode_q;
	wire sck_rise = sck_f & ~sck_prev_q;
	wire sample = prog_mode & sck_rise & (pulse_q == SAMPLE_PULSE);
	wire frame_end = sample & (bit_q == LAST_BIT);
	wire [10:0] di_next = {di_sr_q, sdi_f};
	wire [10:0] ii_next = {ii_sr_q, sii_f};
	wire [7:0] dbyte = di_next[9:2];
	wire [7:0] ibyte = ii_next[9:2];

	wire busy = (timer_q != 16'h0000) | sweep_q;
	wire ld_cmd = frame_end & (ibyte == I_LOAD_CMD);
	wire ld_ahi = frame_end & (ibyte == I_ADDR_HI);
	wire ld_alo = frame_end & (ibyte == I_ADDR_LO);
	wire ld_dlo = frame_end & (ibyte == I_DATA_LO);
	wire ld_dhi = frame_end & (ibyte == I_DATA_HI);
	wire arm_lo = frame_end & (ibyte == I_ARM_LO);
	wire arm_hi = frame_end & (ibyte == I_ARM_HI);
	wire exec_lo = frame_end & (ibyte == I_EXEC_LO) & arm_lo_q & ~busy;
	wire exec_hi = frame_end & (ibyte == I_EXEC_HI) & arm_hi_q & ~busy;
	wire rd_sel = frame_end & ((ibyte == I_RD_LO) | (ibyte == I_RD_HI));
	wire rd_hi = ibyte == I_RD_HI;

	wire wr_locked = ~lock_q[0];
	wire rd_locked = ~lock_q[0] & ~lock_q[1];
	wire do_erase = exec_lo & (cmd_q == C_ERASE);
	wire do_fl_lo = exec_lo & (cmd_q == C_WR_FLASH) & ~wr_locked;
	wire do_fl_hi = exec_hi & (cmd_q == C_WR_FLASH) & ~wr_locked;
	wire do_ee = exec_lo & (cmd_q == C_WR_EE) & ~wr_locked;
	wire do_fuse = exec_lo & (cmd_q == C_WR_FUSE);
	wire do_lock = exec_lo & (cmd_q == C_WR_LOCK);
	wire start_wr = do_fl_lo | do_fl_hi | do_ee | do_fuse | do_lock;
	wire [15:0] wr_time = (do_ee & lv_mode_q) ? WR_T2 : WR_T;

	wire [EE_AW-1:0] ee_addr = addr_q[EE_AW-1:0];
	wire [7:0] fl_lo_rd = flash_lo[addr_q];
	wire [7:0] fl_hi_rd = flash_hi[addr_q];
	wire [7:0] ee_rd = ee_mem[ee_addr];
	wire [7:0] alo = addr_q[7:0];
	wire [7:0] sig_lo = (alo == 8'h00) ? SIG0 :
		(alo == 8'h01) ? SIG1 :
		(alo == 8'h02) ? SIG2 : 8'hFF;
	wire [7:0] sig_hi = (alo == 8'h00) ? CALIB : 8'hFF;
	wire [7:0] fl_sel = rd_hi ? fl_hi_rd : fl_lo_rd;
	wire [7:0] fuse_rd = {fuse_q[5:2], 2'b11, fuse_q[1:0]};
	wire [7:0] rd_byte =
		(cmd_q == C_RD_FLASH) ? (rd_locked ? 8'hFF : fl_sel) :
		(cmd_q == C_RD_EE) ? (rd_locked ? 8'hFF : ee_rd) :
		(cmd_q == C_RD_FUSE) ? fuse_rd :
		(cmd_q == C_RD_SIG) ? (rd_hi ? sig_hi : sig_lo) : 8'hFF;

	wire lv_allow = ~fuse_q[FB_LVPE] & fuse_q[FB_RST_DIS] & ~hv_f;

	// frame bit and pulse counters
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sck_prev_q <= 1'b0;
			pulse_q <= 4'h0;
			bit_q <= 4'h0;
			di_sr_q <= 10'h000;
			ii_sr_q <= 10'h000;
		end else begin
			sck_prev_q <= sck_f;
			if (!prog_mode) begin
				pulse_q <= 4'h0;
				bit_q <= 4'h0;
			end else if (sck_rise) begin
				pulse_q <= pulse_q + 4'h1;
				if (pulse_q == LAST_PULSE) begin
					bit_q <= (bit_q == LAST_BIT) ? 4'h0 : bit_q + 4'h1;
				end
			end
			if (sample) begin
				di_sr_q <= di_next[9:0];
				ii_sr_q <= ii_next[9:0];
			end
		end
	end

	// command, address and data latches
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cmd_q <= 8'h00;
			addr_q <= '0;
			data_lo_q <= 8'hFF;
			data_hi_q <= 8'hFF;
			arm_lo_q <= 1'b0;
			arm_hi_q <= 1'b0;
		end else begin
			if (ld_cmd) begin
				cmd_q <= dbyte;
			end
			if (ld_ahi) begin
				addr_q[FLASH_AW-1] <= dbyte[0];
			end
			if (ld_alo) begin
				addr_q[7:0] <= dbyte;
			end
			if (ld_dlo) begin
				data_lo_q <= dbyte;
			end
			if (ld_dhi) begin
				data_hi_q <= dbyte;
			end
			if (frame_end) begin
				arm_lo_q <= arm_lo;
				arm_hi_q <= arm_hi;
			end
		end
	end

	// fuses, lock bits, self-timed write and erase sweep
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			fuse_q <= FUSE_RESET;
			fuse_act_q <= FUSE_RESET;
			lock_q <= LOCK_RESET;
			timer_q <= 16'h0000;
			sweep_q <= 1'b1;
			idx_q <= '0;
		end else begin
			if (do_fuse) begin
				fuse_q <= {data_lo_q[7:4], data_lo_q[1:0]};
			end
			if (!prog_mode) begin
				fuse_act_q <= fuse_q;
			end
			if (do_erase) begin
				lock_q <= LOCK_RESET;
			end else if (do_lock) begin
				lock_q <= lock_q & {data_lo_q[2], data_lo_q[1]};
			end
			if (start_wr) begin
				timer_q <= wr_time;
			end else if (timer_q != 16'h0000) begin
				timer_q <= timer_q - 16'h0001;
			end
			if (do_erase) begin
				sweep_q <= 1'b1;
				idx_q <= '0;
			end else if (sweep_q) begin
				idx_q <= idx_q + 1'b1;
				if (idx_q == IDX_LAST) begin
					sweep_q <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sweep_q) begin
			flash_lo[idx_q] <= 8'hFF;
			flash_hi[idx_q] <= 8'hFF;
			ee_mem[idx_q[EE_AW-1:0]] <= 8'hFF;
		end else begin
			if (do_fl_lo) begin
				flash_lo[addr_q] <= data_lo_q;
			end
			if (do_fl_hi) begin
				flash_hi[addr_q] <= data_hi_q;
			end
			if (do_ee) begin
				ee_mem[ee_addr] <= data_lo_q;
			end
		end
	end

	// serial output: read data during the next frame, else ready
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			out_sr_q <= 11'h000;
			out_act_q <= 1'b0;
			pin_out_q <= 1'b0;
			oe_n_q <= 1'b1;
		end else begin
			oe_n_q <= ~prog_mode;
			if (rd_sel) begin
				out_sr_q <= {rd_byte, 3'b000};
				out_act_q <= 1'b1;
			end else if (frame_end) begin
				out_act_q <= 1'b0;
			end else if (sample & out_act_q) begin
				out_sr_q <= {out_sr_q[9:0], 1'b0};
			end
			if (out_act_q & sample) begin
				pin_out_q <= out_sr_q[10];
			end else if (!out_act_q) begin
				pin_out_q <= ~busy;
			end
		end
	end

	// low-voltage session, external reset, startup delay
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lv_mode_q <= 1'b0;
			ext_rst_n_q <= 1'b1;
			start_cnt_q <= 24'h000000;
			run_q <= 1'b0;
			bod_en_q <= 1'b0;
		end else begin
			if (!lv_req_q) begin
				lv_mode_q <= 1'b0;
			end else if (!lv_mode_q & lv_allow) begin
				lv_mode_q <= 1'b1;
			end
			ext_rst_n_q <= ~(fuse_act_q[FB_RST_DIS] & ~rst_f & ~hv_f);
			if (prog_mode | ~ext_rst_n_q) begin
				start_cnt_q <= 24'h000000;
				run_q <= 1'b0;
			end else if (start_cnt_q != START_T) begin
				start_cnt_q <= start_cnt_q + 24'h000001;
			end else begin
				run_q <= 1'b1;
			end
			bod_en_q <= ~fuse_act_q[FB_BOD_EN];
		end
	end

	// wishbone slave, one wait state
	wire wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
	wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
	wire [31:0] status_word = {21'h000000, lv_mode_q, prog_mode, busy,
		lock_q, fuse_act_q};
	wire [31:0] rd_word =
		(wb_adr_i == ADR_STATUS) ? status_word :
		(wb_adr_i == ADR_TRIM) ? {24'h000000, trim_q} :
		(wb_adr_i == ADR_CTRL) ? {31'h00000000, lv_req_q} :
		(wb_adr_i == ADR_CALIB) ? {24'h000000, CALIB} : 32'h00000000;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
			trim_q <= TRIM_RESET;
			lv_req_q <= 1'b0;
		end else begin
			ack_q <= wb_req;
			if (wb_req) begin
				dat_q <= rd_word;
			end
			if (wb_wr & (wb_adr_i == ADR_TRIM)) begin
				trim_q <= wb_dat_i[7:0];
			end
			if (wb_wr & (wb_adr_i == ADR_CTRL)) begin
				lv_req_q <= wb_dat_i[0];
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign ready_busy_data_out_pin = pin_out_q;
	assign ready_busy_oe_n = oe_n_q;
	assign ext_reset_n = ext_rst_n_q;
	assign core_run = run_q;
	assign brownout_enable = bod_en_q;
	assign brownout_level = fuse_act_q[FB_BOD_LEVEL];
	assign startup_select = fuse_act_q[1:0];
	assign oscillator_trim_register = trim_q;
	assign low_voltage_mode = lv_mode_q;
endmodule // hvsp_port

// file: hvsp_pkg.sv
package hvsp_pkg;
	localparam int CLK_MHZ = 250;
	localparam int STARTUP_MS = 64;
	localparam int STARTUP_CK = 18;
	localparam int STARTUP_CYCLES = STARTUP_MS * 1000 * CLK_MHZ + STARTUP_CK;
	localparam int WRITE_CYCLES = 256;
	localparam logic [3:0] SAMPLE_PULSE = 4'h7;
	localparam logic [3:0] LAST_PULSE = 4'hF;
	localparam logic [3:0] LAST_BIT = 4'hA;
	localparam logic [7:0] ADR_STATUS = 8'h00;
	localparam logic [7:0] ADR_TRIM = 8'h04;
	localparam logic [7:0] ADR_CTRL = 8'h08;
	localparam logic [7:0] ADR_CALIB = 8'h0C;
	localparam logic [5:0] FUSE_RESET = 6'h14;
	localparam logic [1:0] LOCK_RESET = 2'h3;
	localparam logic [7:0] TRIM_RESET = 8'h00;
	localparam int FB_BOD_LEVEL = 5;
	localparam int FB_BOD_EN = 4;
	localparam int FB_LVPE = 3;
	localparam int FB_RST_DIS = 2;
	localparam logic [7:0] I_LOAD_CMD = 8'h4C;
	localparam logic [7:0] I_ADDR_HI = 8'h1C;
	localparam logic [7:0] I_ADDR_LO = 8'h0C;
	localparam logic [7:0] I_DATA_LO = 8'h2C;
	localparam logic [7:0] I_DATA_HI = 8'h3C;
	localparam logic [7:0] I_ARM_LO = 8'h64;
	localparam logic [7:0] I_ARM_HI = 8'h74;
	localparam logic [7:0] I_EXEC_LO = 8'h6C;
	localparam logic [7:0] I_EXEC_HI = 8'h7C;
	localparam logic [7:0] I_RD_LO = 8'h68;
	localparam logic [7:0] I_RD_HI = 8'h78;
	localparam logic [7:0] C_ERASE = 8'h80;
	localparam logic [7:0] C_WR_FLASH = 8'h10;
	localparam logic [7:0] C_RD_FLASH = 8'h02;
	localparam logic [7:0] C_WR_EE = 8'h11;
	localparam logic [7:0] C_RD_EE = 8'h03;
	localparam logic [7:0] C_WR_FUSE = 8'h40;
	localparam logic [7:0] C_WR_LOCK = 8'h20;
	localparam logic [7:0] C_RD_FUSE = 8'h04;
	localparam logic [7:0] C_RD_SIG = 8'h08;
endpackage

// file: hvsp_sva.sv
`timescale 1ns/1ps
module hvsp_sva (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic high_voltage_detect,
	input wire logic ready_busy_data_out_pin,
	input wire logic ready_busy_oe_n,
	input wire logic ext_reset_n,
	input wire logic brownout_enable,
	input wire logic brownout_level,
	input wire logic [1:0] startup_select,
	input wire logic [7:0] oscillator_trim_register
);
	import hvsp_pkg::*;
	logic [10:0] low_q;
	wire logic req = wb_cyc_i && wb_stb_i;
	wire logic unmapped = !(wb_adr_i inside {ADR_STATUS, ADR_TRIM, ADR_CTRL,
		ADR_CALIB});
	wire logic low_now = !ready_busy_oe_n && !ready_busy_data_out_pin;
	wire logic [10:0] low_d = low_now ? low_q + 11'h001 : 11'h000;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			low_q <= 11'h000;
		end else begin
			low_q <= low_d;
		end
	end
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_next: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	a_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
		else $error("read data moved without ack");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && unmapped
		|-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	a_trim_write: assert property (
		req && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_TRIM
		|=> oscillator_trim_register == $past(wb_dat_i[7:0]))
		else $error("trim write lost");
	a_fuse_frozen: assert property (
		high_voltage_detect && !ready_busy_oe_n
		|-> $stable({brownout_enable, brownout_level, startup_select}))
		else $error("fuse outputs moved in programming");
	a_hv_drive: assert property (
		high_voltage_detect [*8] |-> !ready_busy_oe_n)
		else $error("pin not driven under high voltage");
	a_hv_no_reset: assert property (
		high_voltage_detect [*8] |-> ext_reset_n)
		else $error("external reset under high voltage");
	a_busy_bound: assert property (low_q < 11'h5DC)
		else $error("busy low too long");
endmodule // hvsp_sva
bind hvsp_port hvsp_sva chk (.mclk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .high_voltage_detect,
	.ready_busy_data_out_pin, .ready_busy_oe_n, .ext_reset_n, .brownout_enable,
	.brownout_level, .startup_select, .oscillator_trim_register);

// file: hvsp_prog_model.sv
`timescale 1ns/1ps
module hvsp_prog_model (
	output logic serial_clock_in_pin,
	output logic serial_data_in_pin,
	output logic serial_instr_in_pin,
	output logic reset_high_voltage_pin,
	output logic high_voltage_detect,
	input wire logic ready_busy_data_out_pin
);
	initial begin
		serial_clock_in_pin = 1'b0;
		serial_data_in_pin = 1'b0;
		serial_instr_in_pin = 1'b0;
		reset_high_voltage_pin = 1'b1;
		high_voltage_detect = 1'b0;
	end
	task automatic enter();
		#1;
		reset_high_voltage_pin = 1'b0;
		serial_data_in_pin = 1'b0;
		#30000;
		serial_clock_in_pin = 1'b0;
		#100;
		// 12V raised in the same time step as the reset pin is let go
		high_voltage_detect = 1'b1;
		reset_high_voltage_pin = 1'b1;
		#8100;
	endtask
	task automatic frame(input logic [7:0] dat, input logic [7:0] ins,
		output logic [7:0] rd);
		logic [10:0] d;
		logic [10:0] s;
		#1;
		d = {1'b0, dat, 2'b00};
		s = {1'b0, ins, 2'b00};
		rd = 8'h00;
		for (int b = 0; b < 11; b++) begin
			serial_data_in_pin = d[10-b];
			serial_instr_in_pin = s[10-b];
			for (int p = 0; p < 16; p++) begin
				#16 serial_clock_in_pin = 1'b1;
				if (p == 15 && b < 8) begin
					rd = {rd[6:0], ready_busy_data_out_pin};
				end
				#16 serial_clock_in_pin = 1'b0;
			end
		end
		// released lines must not look like held data
		serial_data_in_pin = ~serial_data_in_pin;
		serial_instr_in_pin = ~serial_instr_in_pin;
		// keep pin changes away from the sampling clock edge
		#3;
	endtask
	// clock low, then high voltage off
	task automatic leave();
		#1;
		serial_clock_in_pin = 1'b0;
		#100;
		high_voltage_detect = 1'b0;
		reset_high_voltage_pin = 1'b0;
	endtask
	task automatic unpin();
		#1;
		reset_high_voltage_pin = 1'b1;
	endtask
endmodule // hvsp_prog_model

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import hvsp_pkg::*;
	logic mclk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, lk;
	logic [7:0] wb_adr_i, rd, cmd, pv;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, q;
	wire logic [31:0] wb_dat_o;
	wire logic wb_ack_o, ready_busy_data_out_pin, ready_busy_oe_n;
	wire logic ext_reset_n, core_run, brownout_enable, brownout_level;
	wire logic low_voltage_mode;
	wire logic [1:0] startup_select;
	wire logic [7:0] oscillator_trim_register;
	wire logic serial_clock_in_pin, serial_data_in_pin, serial_instr_in_pin;
	wire logic reset_high_voltage_pin, high_voltage_detect;
	wire logic rb_line = ready_busy_oe_n ? 1'bz : ready_busy_data_out_pin;
	int miscompares, total_checks, busy_n, cyc_n, k;
	logic [40:0] wb_rows [8] = '{{1'b0, ADR_STATUS, 32'h0000_00D4},
		{1'b1, ADR_TRIM, 32'h0000_00A5}, {1'b0, ADR_TRIM, 32'h0000_00A5},
		{1'b1, ADR_CALIB, 32'h0000_0011}, {1'b0, ADR_CALIB, 32'h0000_005A},
		{1'b0, ADR_CTRL, 32'h0}, {1'b1, 8'h10, 32'h77}, {1'b0, 8'h10, 32'h0}};
	logic [15:0] fr [$] = '{16'h4C08, 16'h0C00, 16'h6800, 16'h6C00, 16'h7800,
		16'h6C00, 16'h4C10, 16'h1C01, 16'h0C05, 16'h2C3A, 16'h6400, 16'h6C00,
		16'h3CC4, 16'h7400, 16'h7C00, 16'h4C02, 16'h1C01, 16'h0C05, 16'h6800,
		16'h6C00, 16'h7800, 16'h6C00, 16'h4C11, 16'h0C07, 16'h2C5E, 16'h6400,
		16'h6C00, 16'h4C03, 16'h0C07, 16'h6800, 16'h6C00, 16'h4C40, 16'h2CBD,
		16'h6400, 16'h6C00, 16'h4C20, 16'h2CFD, 16'h6400, 16'h6C00, 16'h4C10,
		16'h0C06, 16'h2C11, 16'h6400, 16'h6C00, 16'h4C02, 16'h0C06, 16'h6800,
		16'h6C00, 16'h4C20, 16'h2CF9, 16'h6400, 16'h6C00, 16'h4C02, 16'h1C01,
		16'h0C05, 16'h6800, 16'h6C00, 16'h4C80, 16'h6400, 16'h6C00, 16'h4C04,
		16'h6800, 16'h6C00};
	logic [7:0] ex [$] = '{8'hA1, 8'h5A, 8'h3A, 8'hC4, 8'h5E, 8'hFF, 8'hFF,
		8'hBD};
	hvsp_port #(.STARTUP_CYC(50)) uut (.mclk, .resetn, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.serial_clock_in_pin, .serial_data_in_pin, .serial_instr_in_pin,
		.reset_high_voltage_pin, .high_voltage_detect, .ready_busy_data_out_pin,
		.ready_busy_oe_n, .ext_reset_n, .core_run, .brownout_enable,
		.brownout_level, .startup_select, .oscillator_trim_register,
		.low_voltage_mode);
	hvsp_prog_model prog (.serial_clock_in_pin, .serial_data_in_pin,
		.serial_instr_in_pin, .reset_high_voltage_pin, .high_voltage_detect,
		.ready_busy_data_out_pin(rb_line));
	initial mclk = 1'b0;
	always #2 mclk = ~mclk;
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rdat);
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		@(posedge mclk);
		while (wb_ack_o !== 1'b1) @(posedge mclk);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	always @(posedge mclk) begin
		if (rb_line === 1'b0) busy_n++;
		cyc_n++;
		if (cyc_n == 110000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		resetn = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i, lk} = 4'h0;
		{wb_adr_i, wb_sel_i, wb_dat_i, pv, cmd} = 60'h0;
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		repeat (600) @(posedge mclk);
		chk({brownout_enable, brownout_level, startup_select, core_run}, 5'h01);
		for (int i = 0; i < 8; i++) begin
			wb(wb_rows[i][40], wb_rows[i][39:32], wb_rows[i][31:0], q);
			if (!wb_rows[i][40]) chk(q, wb_rows[i][31:0]);
		end
		chk(oscillator_trim_register, 8'hA5);
		prog.enter();
		foreach (fr[i]) begin
			busy_n = 0;
			prog.frame(fr[i][7:0], fr[i][15:8], rd);
			if (fr[i][15:8] == I_LOAD_CMD) cmd = fr[i][7:0];
			if (pv inside {I_RD_LO, I_RD_HI} && fr[i][15:8] == I_EXEC_LO) begin
				chk(rd, ex[k]);
				k++;
			end
			if (pv inside {I_ARM_LO, I_ARM_HI}) begin
				while (rb_line === 1'b0) @(posedge mclk);
				chk(busy_n, cmd == C_ERASE ? 512 : (cmd == C_WR_FLASH && lk) ? 0 : WRITE_CYCLES);
				if (cmd == C_WR_LOCK) lk = 1'b1;
			end
			pv = fr[i][15:8];
		end
		chk(brownout_enable, 1'b0);
		prog.leave();
		repeat (20) @(posedge mclk);
		chk(ext_reset_n, 1'b0);
		prog.unpin();
		repeat (100) @(posedge mclk);
		chk({brownout_enable, brownout_level, startup_select, core_run}, 5'h1B);
		wb(1'b0, ADR_STATUS, 32'h0, q);
		chk(q, 32'h0000_00ED);
		wb(1'b1, ADR_CTRL, 32'h1, q);
		repeat (2) @(posedge mclk);
		chk(low_voltage_mode, 1'b0);
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		repeat (600) @(posedge mclk);
		chk({brownout_enable, brownout_level, startup_select, core_run}, 5'h01);
		wb(1'b1, ADR_CTRL, 32'h1, q);
		repeat (2) @(posedge mclk);
		chk(low_voltage_mode, 1'b1);
		wb(1'b0, ADR_STATUS, 32'h0, q);
		chk(q, 32'h0000_06D4);
		end_sim();
	end
endmodule // tb_top
